/* File: src/ldc_cfg.svh */
// Register indexes, field positions, reset values and unimplemented read values
// ==========================================================================
`ifndef LDC_CFG_SVH
`define LDC_CFG_SVH

`define LDC_NUM_DEV 11
`define LDC_NUM_VEND 15
`define LDC_IDX_BANK_MIN 8'h30
`define LDC_IDX_ACT 8'h30
`define LDC_IDX_IO0H 8'h60
`define LDC_IDX_IO0L 8'h61
`define LDC_IDX_IO1H 8'h62
`define LDC_IDX_IO1L 8'h63
`define LDC_IDX_IRQ 8'h70
`define LDC_IDX_IRQT 8'h71
`define LDC_IDX_DMA0 8'h74
`define LDC_IDX_DMA1 8'h75
`define LDC_IDX_VEND_LO 8'hF0
`define LDC_IDX_VEND_HI 8'hFE
`define LDC_ACT_EN_BIT 0
`define LDC_IRQ_WAKE_BIT 4
`define LDC_IRQT_LEVEL_BIT 0
`define LDC_IRQT_POL_BIT 1
`define LDC_RST_BYTE 8'h00
`define LDC_DMA_NONE 3'h4
`define LDC_RD_UNIMPL 8'h00
`define LDC_RD_DMA_UNIMPL 8'h04

`endif

/* File: src/ldc_pkg.sv */
// Types shared by the configuration bank modules
package ldc_pkg;
   typedef logic [7:0] ldc_byte_t;
   typedef logic [3:0] ldc_dev_t;
   typedef struct packed {
      logic active;
      logic [15:0] io_base0;
      logic [15:0] io_base1;
      logic [3:0] irq_num;
      logic irq_wake;
      logic irq_level;
      logic irq_high;
      logic [2:0] dma0;
      logic [2:0] dma1;
   } ldc_res_t;
endpackage

/* File: src/ldc_acc_if.sv */
// Bank access carrier between decoder and register banks
`timescale 1ns/10ps
`include "ldc_cfg.svh"
interface ldc_acc_if;
   import ldc_pkg::*;
   logic [`LDC_NUM_DEV-1:0] wr_sel;
   ldc_byte_t index;
   ldc_byte_t wdata;
   modport ctrl (output wr_sel, output index, output wdata);
   modport bank (input wr_sel, input index, input wdata);
endinterface

/* File: src/ldc_bank.sv */
// One logical device bank of standard configuration registers
`timescale 1ns/10ps
`include "ldc_cfg.svh"
module ldc_bank
   import ldc_pkg::*;
#(
   parameter int unsigned DEV = 0
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic resetn_i,
   // Access
   ldc_acc_if.bank acc,
   // State and read port
   output ldc_res_t res_o,
   output ldc_byte_t rdata_o,
   output logic hit_o
);
   ldc_byte_t act_q, io0h_q, io0l_q, io1h_q, io1l_q, irq_q, irqt_q;
   logic [2:0] dma0_q, dma1_q;
   ldc_byte_t vend_q [`LDC_NUM_VEND];
   logic we;
   logic [3:0] voff;

   assign we = acc.wr_sel[DEV];
   assign voff = acc.index[3:0];

   // ==================================================================
   // Standard registers
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         act_q <= `LDC_RST_BYTE;
         io0h_q <= `LDC_RST_BYTE;
         io0l_q <= `LDC_RST_BYTE;
         io1h_q <= `LDC_RST_BYTE;
         io1l_q <= `LDC_RST_BYTE;
         irq_q <= `LDC_RST_BYTE;
         irqt_q <= `LDC_RST_BYTE;
         dma0_q <= `LDC_DMA_NONE;
         dma1_q <= `LDC_DMA_NONE;
      end else if (we) begin
         if (acc.index == `LDC_IDX_ACT) begin
            act_q <= {7'h00, acc.wdata[`LDC_ACT_EN_BIT]};
         end else if (acc.index == `LDC_IDX_IO0H) begin
            io0h_q <= acc.wdata;
         end else if (acc.index == `LDC_IDX_IO0L) begin
            io0l_q <= acc.wdata;
         end else if (acc.index == `LDC_IDX_IO1H) begin
            io1h_q <= acc.wdata;
         end else if (acc.index == `LDC_IDX_IO1L) begin
            io1l_q <= acc.wdata;
         end else if (acc.index == `LDC_IDX_IRQ) begin
            irq_q <= {3'h0, acc.wdata[4:0]};
         end else if (acc.index == `LDC_IDX_IRQT) begin
            irqt_q <= {6'h00, acc.wdata[1:0]};
         end else if (acc.index == `LDC_IDX_DMA0) begin
            dma0_q <= acc.wdata[2:0];
         end else if (acc.index == `LDC_IDX_DMA1) begin
            dma1_q <= acc.wdata[2:0];
         end
      end
   end

   // ==================================================================
   // Vendor-defined registers
   genvar g;
   generate
      for (g = 0; g < `LDC_NUM_VEND; g++) begin : g_vend
         always_ff @(posedge clock_i or negedge resetn_i) begin
            if (!resetn_i) begin
               vend_q[g] <= `LDC_RST_BYTE;
            end else if (we && acc.index[7:4] == 4'hF && voff == 4'(g)) begin
               vend_q[g] <= acc.wdata;
            end
         end
      end
   endgenerate

   // ==================================================================
   // Read mux
   always_comb begin
      hit_o = 1'b1;
      rdata_o = `LDC_RD_UNIMPL;
      if (acc.index == `LDC_IDX_ACT) begin
         rdata_o = act_q;
      end else if (acc.index == `LDC_IDX_IO0H) begin
         rdata_o = io0h_q;
      end else if (acc.index == `LDC_IDX_IO0L) begin
         rdata_o = io0l_q;
      end else if (acc.index == `LDC_IDX_IO1H) begin
         rdata_o = io1h_q;
      end else if (acc.index == `LDC_IDX_IO1L) begin
         rdata_o = io1l_q;
      end else if (acc.index == `LDC_IDX_IRQ) begin
         rdata_o = irq_q;
      end else if (acc.index == `LDC_IDX_IRQT) begin
         rdata_o = irqt_q;
      end else if (acc.index == `LDC_IDX_DMA0) begin
         rdata_o = {5'h00, dma0_q};
      end else if (acc.index == `LDC_IDX_DMA1) begin
         rdata_o = {5'h00, dma1_q};
      end else if (acc.index >= `LDC_IDX_VEND_LO && acc.index <= `LDC_IDX_VEND_HI) begin
         rdata_o = vend_q[voff];
      end else begin
         hit_o = 1'b0;
      end
   end

   always_comb begin
      res_o.active = act_q[`LDC_ACT_EN_BIT];
      res_o.io_base0 = {io0h_q, io0l_q};
      res_o.io_base1 = {io1h_q, io1l_q};
      res_o.irq_num = irq_q[3:0];
      res_o.irq_wake = irq_q[`LDC_IRQ_WAKE_BIT];
      res_o.irq_level = irqt_q[`LDC_IRQT_LEVEL_BIT];
      res_o.irq_high = irqt_q[`LDC_IRQT_POL_BIT];
      res_o.dma0 = dma0_q;
      res_o.dma1 = dma1_q;
   end
endmodule

/* File: src/ldc_route.sv */
// Routes one block's interrupt and DMA requests onto the shared lines
`timescale 1ns/10ps
`include "ldc_cfg.svh"
module ldc_route
   import ldc_pkg::*;
(
   // Configuration
   input ldc_res_t res_i,
   // Block requests
   input wire logic irq_req_i,
   input wire logic dma0_req_i,
   input wire logic dma1_req_i,
   // Routed lines
   output logic [15:0] irq_hit_o,
   output logic [15:0] irq_val_o,
   output logic [3:0] dma_o,
   output logic wake_o
);
   logic irq_on;
   logic lvl;

   // Zero selects nothing, inactive blocks attach nothing
   assign irq_on = res_i.active && (res_i.irq_num != 4'h0);
   assign lvl = res_i.irq_high ? irq_req_i : ~irq_req_i;
   assign wake_o = irq_on && res_i.irq_wake && irq_req_i;

   genvar g;
   generate
      for (g = 0; g < 16; g++) begin : g_line
         assign irq_hit_o[g] = irq_on && (res_i.irq_num == 4'(g));
         assign irq_val_o[g] = irq_on && (res_i.irq_num == 4'(g)) && lvl;
      end
      for (g = 0; g < 4; g++) begin : g_dma
         // Value 4 never matches a channel; 5-7 likewise ignored
         assign dma_o[g] = res_i.active &&
            ((dma0_req_i && res_i.dma0 == 3'(g)) || (dma1_req_i && res_i.dma1 == 3'(g)));
      end
   endgenerate
endmodule

/* File: src/ldc_top.sv */
// Index/data configuration port with banked logical device registers
`timescale 1ns/10ps
`include "ldc_cfg.svh"
module ldc_top
   import ldc_pkg::*;
(
   // Clock and reset
   input wire logic clock_i,
   input wire logic resetn_i,
   // Configuration data port access (same clock domain)
   input wire logic cfg_wr_i,
   input wire logic [7:0] cfg_index_i,
   input wire logic [7:0] cfg_wdata_i,
   input wire logic [3:0] logical_device_selector_i,
   output logic [7:0] cfg_rdata_o,
   // Block requests
   input wire logic [`LDC_NUM_DEV-1:0] irq_req_i,
   input wire logic [`LDC_NUM_DEV-1:0] dma0_req_i,
   input wire logic [`LDC_NUM_DEV-1:0] dma1_req_i,
   // Resources
   output logic [`LDC_NUM_DEV-1:0] active_o,
   output logic [`LDC_NUM_DEV*16-1:0] io_base0_o,
   output logic [`LDC_NUM_DEV*16-1:0] io_base1_o,
   output logic [`LDC_NUM_DEV-1:0] irq_level_o,
   output logic [15:0] irq_line_o,
   output logic [3:0] dma_req_o,
   output logic wake_o
);
   ldc_acc_if acc();
   ldc_res_t res [`LDC_NUM_DEV];
   ldc_byte_t bank_rd [`LDC_NUM_DEV];
   logic [`LDC_NUM_DEV-1:0] bank_hit, wk;
   logic [15:0] hit_m [`LDC_NUM_DEV];
   logic [15:0] val_m [`LDC_NUM_DEV];
   logic [3:0] dma_m [`LDC_NUM_DEV];
   logic in_bank;
   logic dev_ok;
   logic [15:0] line_d;
   logic [3:0] dma_d;
   logic [7:0] rd_d;

   // ==================================================================
   // Access decode
   assign in_bank = cfg_index_i >= `LDC_IDX_BANK_MIN;
   assign dev_ok = logical_device_selector_i < 4'(`LDC_NUM_DEV);
   assign acc.index = cfg_index_i;
   assign acc.wdata = cfg_wdata_i;

   genvar g;
   generate
      for (g = 0; g < `LDC_NUM_DEV; g++) begin : g_dev
         assign acc.wr_sel[g] = cfg_wr_i && in_bank &&
            (logical_device_selector_i == 4'(g));
         ldc_bank #(.DEV(g)) u_bank (
            .clock_i(clock_i),
            .resetn_i(resetn_i),
            .acc(acc),
            .res_o(res[g]),
            .rdata_o(bank_rd[g]),
            .hit_o(bank_hit[g])
         );
         ldc_route u_route (
            .res_i(res[g]),
            .irq_req_i(irq_req_i[g]),
            .dma0_req_i(dma0_req_i[g]),
            .dma1_req_i(dma1_req_i[g]),
            .irq_hit_o(hit_m[g]),
            .irq_val_o(val_m[g]),
            .dma_o(dma_m[g]),
            .wake_o(wk[g])
         );
         assign active_o[g] = res[g].active;
         // Base addresses shown only while active
         assign io_base0_o[g*16 +: 16] = res[g].active ? res[g].io_base0 : 16'h0000;
         assign io_base1_o[g*16 +: 16] = res[g].active ? res[g].io_base1 : 16'h0000;
         assign irq_level_o[g] = res[g].irq_level;
      end
   endgenerate

   // ==================================================================
   // Read data: unimplemented reads give 00h, DMA selects give 04h
   always_comb begin
      rd_d = `LDC_RD_UNIMPL;
      if (in_bank && dev_ok) begin
         if (bank_hit[logical_device_selector_i]) begin
            rd_d = bank_rd[logical_device_selector_i];
         end
      end else if (in_bank && (cfg_index_i == `LDC_IDX_DMA0 ||
                               cfg_index_i == `LDC_IDX_DMA1)) begin
         rd_d = `LDC_RD_DMA_UNIMPL;
      end
   end

   // ==================================================================
   // Shared interrupt and DMA lines; an idle line sits low, but high when the block on it has irq_high clear
   always_comb begin
      line_d = 16'h0000;
      dma_d = 4'h0;
      for (int d = 0; d < `LDC_NUM_DEV; d++) begin
         line_d = line_d | (hit_m[d] & val_m[d]);
         dma_d = dma_d | dma_m[d];
      end
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cfg_rdata_o <= 8'h00;
      end else begin
         cfg_rdata_o <= rd_d;
      end
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         irq_line_o <= 16'h0000;
         dma_req_o <= 4'h0;
         wake_o <= 1'b0;
      end else begin
         irq_line_o <= line_d;
         dma_req_o <= dma_d;
         wake_o <= |wk;
      end
   end
endmodule

/* File: tb/ldc_top_checker.sv */
// Port assertions for the configuration bank top
`timescale 1ns/10ps
module ldc_top_checker (
   // Clock and reset
   input wire logic clock_i,
   input wire logic resetn_i,
   // Port access
   input wire logic cfg_wr_i,
   input wire logic [7:0] cfg_index_i,
   input wire logic [7:0] cfg_wdata_i,
   input wire logic [3:0] logical_device_selector_i,
   input wire logic [7:0] cfg_rdata_o,
   // Requests and resources
   input wire logic [10:0] irq_req_i,
   input wire logic [10:0] dma0_req_i,
   input wire logic [10:0] dma1_req_i,
   input wire logic [10:0] active_o,
   input wire logic [175:0] io_base0_o,
   input wire logic [15:0] irq_line_o,
   input wire logic [3:0] dma_req_o,
   input wire logic wake_o
);
   // ==========
   // Helpers
   logic io_leak;
   always_comb begin
      io_leak = 1'b0;
      for (int g = 0; g < 11; g++) begin
         if (!active_o[g] && io_base0_o[g*16+:16] != 16'h0000) begin
            io_leak = 1'b1;
         end
      end
   end
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!resetn_i);
   // ==========
   // Assertions
   act_write_a:
   assert property (cfg_wr_i && cfg_index_i == 8'h30 && logical_device_selector_i < 4'hB
      |=> active_o[$past(logical_device_selector_i)] == $past(cfg_wdata_i[0]))
      else $error("activation bit not taken");
   act_resv_a:
   assert property (cfg_index_i == 8'h30 |=> cfg_rdata_o[7:1] == 7'h00)
      else $error("activation reserved bits not zero");
   unimpl_read_a:
   assert property (logical_device_selector_i > 4'hA && cfg_index_i != 8'h74
      && cfg_index_i != 8'h75 |=> cfg_rdata_o == 8'h00) else $error("bad unmapped read");
   dma_none_read_a:
   assert property (logical_device_selector_i > 4'hA && cfg_index_i inside {8'h74, 8'h75}
      |=> cfg_rdata_o == 8'h04) else $error("bad unmapped dma read");
   low_index_a:
   assert property (cfg_index_i < 8'h30 |=> cfg_rdata_o == 8'h00)
      else $error("low index read not zero");
   io_inactive_a:
   assert property (!io_leak) else $error("base shown while inactive");
   line_zero_a:
   assert property (irq_line_o[0] == 1'b0) else $error("line zero driven");
   wake_idle_a:
   assert property (irq_req_i == 11'h000 |=> !wake_o) else $error("wake without request");
   dma_idle_a:
   assert property ((dma0_req_i | dma1_req_i) == 11'h000 |=> dma_req_o == 4'h0)
      else $error("dma without request");
   res_idle_a:
   assert property (active_o == 11'h000 |=> irq_line_o == 16'h0000 && dma_req_o == 4'h0)
      else $error("lines driven while all inactive");
endmodule
bind ldc_top ldc_top_checker i_chk (.clock_i(clock_i), .resetn_i(resetn_i),
   .cfg_wr_i(cfg_wr_i), .cfg_index_i(cfg_index_i), .cfg_wdata_i(cfg_wdata_i),
   .logical_device_selector_i(logical_device_selector_i), .cfg_rdata_o(cfg_rdata_o),
   .irq_req_i(irq_req_i), .dma0_req_i(dma0_req_i), .dma1_req_i(dma1_req_i),
   .active_o(active_o), .io_base0_o(io_base0_o), .irq_line_o(irq_line_o),
   .dma_req_o(dma_req_o), .wake_o(wake_o));

/* File: tb/ldc_top_tb.sv */
// Self-checking bench for the configuration bank top
`timescale 1ns/10ps
module ldc_top_tb;
   logic clock_i = 1'b0;
   logic resetn_i = 1'b0;
   logic cfg_wr_i = 1'b0;
   logic [7:0] cfg_index_i = 8'h00;
   logic [7:0] cfg_wdata_i = 8'h00;
   logic [3:0] logical_device_selector_i = 4'h0;
   logic [10:0] irq_req_i = 11'h000;
   logic [10:0] dma0_req_i = 11'h000;
   logic [10:0] dma1_req_i = 11'h000;
   logic [7:0] cfg_rdata_o;
   logic [10:0] active_o;
   logic [10:0] irq_level_o;
   logic [175:0] io_base0_o;
   logic [175:0] io_base1_o;
   logic [15:0] irq_line_o;
   logic [3:0] dma_req_o;
   logic wake_o;
   int num_errors = 0;
   int samples_checked = 0;
   always #5 clock_i = ~clock_i;
   ldc_top i_dut (.clock_i(clock_i), .resetn_i(resetn_i), .cfg_wr_i(cfg_wr_i),
      .cfg_index_i(cfg_index_i), .cfg_wdata_i(cfg_wdata_i),
      .logical_device_selector_i(logical_device_selector_i), .cfg_rdata_o(cfg_rdata_o),
      .irq_req_i(irq_req_i), .dma0_req_i(dma0_req_i), .dma1_req_i(dma1_req_i),
      .active_o(active_o), .io_base0_o(io_base0_o), .io_base1_o(io_base1_o),
      .irq_level_o(irq_level_o), .irq_line_o(irq_line_o), .dma_req_o(dma_req_o),
      .wake_o(wake_o));
   // ==========
   // Shared tasks
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] s, input logic [7:0] i, input logic [7:0] d);
      @(posedge clock_i) #1;
      logical_device_selector_i = s;
      cfg_index_i = i;
      cfg_wdata_i = d;
      cfg_wr_i = 1'b1;
      @(posedge clock_i) #1;
      cfg_wr_i = 1'b0;
   endtask
   task automatic rd(input logic [3:0] s, input logic [7:0] i, input logic [7:0] e);
      logical_device_selector_i = s;
      cfg_index_i = i;
      @(posedge clock_i) #1;
      chk(16'(cfg_rdata_o), 16'(e));
   endtask
   task automatic tick();
      @(posedge clock_i) #1;
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // ==========
   // Scenarios
   task automatic t_reset();
      for (int s = 0; s < 11; s++) begin
         rd(4'(s), 8'h30, 8'h00);
         rd(4'(s), 8'h70, 8'h00);
         rd(4'(s), 8'h75, 8'h04);
      end
      $display("reset test done");
   endtask
   task automatic t_regs();
      logic [7:0] ix [11] = '{8'h30, 8'h60, 8'h61, 8'h62, 8'h63, 8'h70, 8'h71, 8'h74, 8'h75,
         8'hF0, 8'hFE};
      logic [7:0] mk [11] = '{8'h01, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h1F, 8'h03, 8'h04, 8'h04,
         8'hFF, 8'hFF};
      for (int k = 0; k < 11; k++) begin
         // DMA selects get reserved bits set but a legal field value
         wr(4'h3, ix[k], (ix[k] inside {8'h74, 8'h75}) ? 8'hFC : 8'hFF);
         rd(4'h3, ix[k], mk[k]);
      end
      rd(4'h4, 8'h60, 8'h00);
      wr(4'h3, 8'h60, 8'h12);
      wr(4'h3, 8'h61, 8'h34);
      wr(4'h3, 8'h62, 8'hAB);
      wr(4'h3, 8'h63, 8'hCD);
      chk(io_base0_o[63:48], 16'h1234);
      chk(io_base1_o[63:48], 16'hABCD);
      chk(16'(irq_level_o), 16'h0008);
      wr(4'h3, 8'h30, 8'hFE);
      chk(io_base0_o[63:48], 16'h0000);
      wr(4'h3, 8'h30, 8'h01);
      chk(io_base0_o[63:48], 16'h1234);
      $display("register test done");
   endtask
   task automatic t_unmap();
      wr(4'h3, 8'h40, 8'h5A);
      rd(4'h3, 8'h40, 8'h00);
      wr(4'h3, 8'hFF, 8'h5A);
      rd(4'h3, 8'hFF, 8'h00);
      rd(4'h3, 8'h20, 8'h00);
      wr(4'hB, 8'h30, 8'h01);
      chk(16'(active_o), 16'h0008);
      rd(4'hB, 8'h74, 8'h04);
      rd(4'hF, 8'h30, 8'h00);
      $display("unmapped test done");
   endtask
   task automatic t_irq();
      wr(4'h2, 8'h30, 8'h01);
      wr(4'h2, 8'h71, 8'h02);
      irq_req_i[2] = 1'b1;
      for (int n = 1; n < 16; n++) begin
         wr(4'h2, 8'h70, 8'(n));
         tick();
         chk(irq_line_o, 16'(1 << n));
      end
      wr(4'h2, 8'h71, 8'h00);
      tick();
      chk(irq_line_o, 16'h0000);
      irq_req_i[2] = 1'b0;
      tick();
      chk(irq_line_o, 16'h8000);
      wr(4'h2, 8'h70, 8'h15);
      irq_req_i[2] = 1'b1;
      tick();
      chk(16'(wake_o), 16'h0001);
      wr(4'h2, 8'h70, 8'h10);
      tick();
      chk({irq_line_o[15:1], wake_o}, 16'h0000);
      wr(4'h2, 8'h71, 8'h02);
      wr(4'h2, 8'h70, 8'h05);
      wr(4'h2, 8'h30, 8'h00);
      tick();
      chk(irq_line_o, 16'h0000);
      $display("interrupt test done");
   endtask
   task automatic t_dma();
      wr(4'h5, 8'h30, 8'h01);
      dma0_req_i[5] = 1'b1;
      for (int c = 0; c < 5; c++) begin
         wr(4'h5, 8'h74, 8'(c));
         tick();
         chk(16'(dma_req_o), 16'(c < 4 ? (1 << c) : 0));
      end
      dma1_req_i[5] = 1'b1;
      for (int c = 0; c < 5; c++) begin
         wr(4'h5, 8'h75, 8'(c));
         tick();
         chk(16'(dma_req_o), 16'(c < 4 ? (1 << c) : 0));
      end
      $display("dma test done");
   endtask
   task automatic t_rerun();
      resetn_i = 1'b0;
      tick();
      tick();
      resetn_i = 1'b1;
      chk(16'(active_o), 16'h0000);
      chk(16'(dma_req_o), 16'h0000);
      rd(4'h5, 8'h74, 8'h04);
      rd(4'h3, 8'h61, 8'h00);
      rd(4'h2, 8'h70, 8'h00);
      $display("reset rerun test done");
   endtask
   initial begin
      repeat (10) @(posedge clock_i);
      #1 resetn_i = 1'b1;
      t_reset();
      t_regs();
      t_unmap();
      t_irq();
      t_dma();
      t_rerun();
      stop_test();
   end
   // Far above the few hundred cycles the tests take
   initial begin
      #50us;
      num_errors++;
      stop_test();
   end
endmodule
